// *** design/spm_fifo.sv ***
`timescale 1ns/1ns
// small fifo with a registered output word
module spm_fifo import spm_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr; // write pointer with wrap bit
		logic [AW:0] rd; // read pointer with wrap bit
		logic oval; // output word holds data
		logic [W-1:0] odat; // output word
	} spm_fifo_s;
	spm_fifo_s cur_ff, nxt;
	logic [W-1:0] mem [DEPTH]; // storage, no reset needed
	logic mem_empty;
	logic load;
	// the output register counts as one extra slot beyond DEPTH
	always_comb begin
		nxt = cur_ff;
		mem_empty = (cur_ff.wr == cur_ff.rd);
		in_ready = ((cur_ff.wr - cur_ff.rd) != (AW + 1)'(DEPTH));
		load = !mem_empty && (!cur_ff.oval || out_ready);
		if (in_valid && in_ready) begin
			nxt.wr = cur_ff.wr + 1'b1;
		end
		if (load) begin
			nxt.rd = cur_ff.rd + 1'b1;
			nxt.odat = mem[cur_ff.rd[AW-1:0]];
			nxt.oval = 1'b1;
		end else if (out_ready) begin
			nxt.oval = 1'b0; // word taken, nothing behind it
		end
		out_valid = cur_ff.oval;
		out_data = cur_ff.odat;
	end
	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt;
		end
	end
	// storage write
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[cur_ff.wr[AW-1:0]] <= in_data;
		end
	end
endmodule : spm_fifo

// *** design/spm_mover.sv ***
// Overview of operation
// - qualify inc, dec by 8-of-10, flag by 3-of-4
// - lone differing valid pointer is ignored
// - two differing normal pointers move offset
// - single-bit error changes neither flow nor state
// - three states; two normal pointers enter normal
// - two chain pointers; chain follows head offset
// - two ais enter ais; two normal or two chain leave
// - ais state forces output bytes to ff outside bypass
// - new offset marks j1 with jump flag
// - flag pair encodes overhead, j0, payload, j1
// - twelve sts-1s, up to twelve j1, one trace
// - envelope flag follows real payload slots only
// - no j1 for sts in ais
// - only chain head produces j1
// - markers follow every pointer movement
// - per-quad mover; overhead bytes pass through outside ais
// - chain members follow the previous sts-1, any length, never sts 0
// - inverted d bits: decrement, h3 carries data
// - inverted i bits: increment, stuff byte empty
// - envelope flag high h3, low stuff slot
// - jump flag set by a newly taken offset or by leaving ais
// - 0110 same, 1001 new, all ones ais
// - word: four flag, two spare, ten offset
// - bypass drives both flags to zero
`timescale 1ns/1ns
module spm_mover import spm_pkg::*; (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// byte stream from the alignment fifo
	input wire logic [DATA_W-1:0] IN_DATA,
	input wire logic IN_VALID,
	input wire logic IN_FRAME,
	output logic IN_READY,
	// mode
	input wire logic BYPASS,
	// stream toward the user logic
	output logic [DATA_W-1:0] OUT_DATA,
	output logic OUT_PAYLOAD_ENVELOPE_FLAG,
	output logic OUT_TRACE_OR_PATH_START_FLAG,
	output logic OUT_POINTER_JUMP_FLAG,
	output logic [STS_W-1:0] OUT_STS,
	output logic OUT_VALID,
	input wire logic OUT_READY
);
	typedef struct packed {
		logic [3:0] sts; // sts-1 index of the next byte
		logic [6:0] col; // column inside that sts-1
		logic [3:0] row; // row of the frame
		logic [11:0][7:0] h1; // first pointer byte of each sts-1
		logic [11:0][OFF_W-1:0] off; // current offset per sts-1
		logic [11:0] valid; // offset has been established
		spm_state_e [11:0] st; // interpreter state per sts-1
		spm_kind_e [11:0] last; // class of previous pointer word
		logic [11:0] diff; // previous normal pointer differed
		logic [11:0] inc; // positive justification this frame
		logic [11:0] dec; // negative justification this frame
		logic [11:0] jump; // next j1 must carry the jump flag
		logic [11:0][3:0] head; // chain head feeding each sts-1
	} spm_mover_s;
	spm_mover_s cur_ff, nxt;
	// pointer word votes
	logic [15:0] word;
	logic [OFF_W-1:0] pdiff;
	logic flag_same, flag_new, inc_word, dec_word, inc_maj, dec_maj;
	// slot decode
	logic take;
	logic [3:0] sts, hs, psts;
	logic [6:0] col;
	logic [3:0] row;
	logic at_h2, in_pay, h3_slot, stuff_slot, carries, j1, trace, payload_envelope_flag;
	logic [OFF_W-1:0] ppos;
	spm_kind_e kind;
	spm_state_e st_new;
	logic fifo_ready;
	logic [FIFO_W-1:0] fifo_in;
	// the word as it stands when the second pointer byte arrives
	assign word = {cur_ff.h1[sts], IN_DATA};
	assign pdiff = word[OFF_W-1:0] ^ cur_ff.off[sts];
	// flag majority: three of four bits decide the pattern
	spm_vote #(.W(4), .MIN(VOTE_FLAG)) u_vote_same (
		.bits(~(word[15:12] ^ FLAG_SAME)),
		.hit(flag_same)
	);
	spm_vote #(.W(4), .MIN(VOTE_FLAG)) u_vote_new (
		.bits(~(word[15:12] ^ FLAG_NEW)),
		.hit(flag_new)
	);
	// whole-word agreement with an inverted i or d pattern
	spm_vote #(.W(OFF_W), .MIN(VOTE_WORD)) u_vote_incw (
		.bits(~(pdiff ^ MASK_INC)),
		.hit(inc_word)
	);
	spm_vote #(.W(OFF_W), .MIN(VOTE_WORD)) u_vote_decw (
		.bits(~(pdiff ^ MASK_DEC)),
		.hit(dec_word)
	);
	// five-bit majority over the i and d positions themselves
	spm_vote #(.W(5), .MIN(VOTE_JUST)) u_vote_inc (
		.bits({pdiff[9], pdiff[7], pdiff[5], pdiff[3], pdiff[1]}),
		.hit(inc_maj)
	);
	spm_vote #(.W(5), .MIN(VOTE_JUST)) u_vote_dec (
		.bits({pdiff[8], pdiff[6], pdiff[4], pdiff[2], pdiff[0]}),
		.hit(dec_maj)
	);
	// output buffer; its fullness stalls the whole slot counter
	spm_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK),
		.nrst(NRST),
		.in_valid(take),
		.in_ready(fifo_ready),
		.in_data(fifo_in),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY),
		.out_data({OUT_POINTER_JUMP_FLAG, OUT_STS, OUT_PAYLOAD_ENVELOPE_FLAG,
			OUT_TRACE_OR_PATH_START_FLAG, OUT_DATA})
	);
	assign IN_READY = fifo_ready;
	// slot position, pointer interpretation and marker generation
	always_comb begin
		nxt = cur_ff;
		take = IN_VALID && fifo_ready;
		// a frame pulse pins this byte to the first slot
		sts = IN_FRAME ? 4'h0 : cur_ff.sts;
		col = IN_FRAME ? 7'h00 : cur_ff.col;
		row = IN_FRAME ? 4'h0 : cur_ff.row;
		psts = sts - 4'h1;
		at_h2 = take && (row == ROW_PTR) && (col == COL_H2);
		// classify the word; all ones wins over everything else
		if (word == WORD_AIS) begin
			kind = KIND_AIS;
		end else if (flag_new && word[OFF_W-1:0] == PTR_CHAIN) begin
			kind = KIND_CHAIN;
		end else if ((flag_same || flag_new) && cur_ff.valid[sts] && cur_ff.st[sts] == VALID_POINTER_STATE
			&& ((inc_word && inc_maj) || (dec_word && dec_maj))) begin
			kind = KIND_NORMAL; // justification word still counts as normal
		end else if ((flag_same || flag_new) && word[OFF_W-1:0] <= OFF_MAX) begin
			kind = KIND_NORMAL;
		end else begin
			kind = KIND_OTHER; // spare or unresolved patterns stay out
		end
		st_new = cur_ff.st[sts];
		// advance the slot counters
		if (take) begin
			nxt.sts = sts + 4'h1;
			nxt.col = col;
			nxt.row = row;
			if (sts == NUM_STS - 4'h1) begin
				nxt.sts = 4'h0;
				nxt.col = col + 7'h01;
				if (col == NUM_COLS - 7'h01) begin
					nxt.col = 7'h00;
					nxt.row = (row == NUM_ROWS - 4'h1) ? 4'h0 : row + 4'h1;
				end
			end
			if (row == ROW_PTR && col == COL_H1) begin
				nxt.h1[sts] = IN_DATA;
			end
		end
		// pointer word complete: states, offsets and justifications
		if (at_h2) begin
			nxt.inc[sts] = 1'b0;
			nxt.dec[sts] = 1'b0;
			// a state changes only on two consecutive words of one class
			if (kind == cur_ff.last[sts] && kind != KIND_OTHER) begin
				case (kind)
					KIND_NORMAL: st_new = VALID_POINTER_STATE;
					KIND_AIS: st_new = AIS_STATE;
					KIND_CHAIN: st_new = CHAINED_PAYLOAD_STATE;
					default: st_new = cur_ff.st[sts];
				endcase
			end
			// leaving ais makes the generator flag new data
			if (cur_ff.st[sts] == AIS_STATE && st_new != AIS_STATE) begin
				nxt.jump[sts] = 1'b1;
			end
			nxt.st[sts] = st_new;
			nxt.last[sts] = kind;
			nxt.diff[sts] = 1'b0;
			if (kind == KIND_NORMAL) begin
				if (cur_ff.valid[sts] && cur_ff.st[sts] == VALID_POINTER_STATE && inc_word && inc_maj) begin
					// stuff byte after h3 is empty, offset steps up
					nxt.inc[sts] = 1'b1;
					nxt.off[sts] = (cur_ff.off[sts] == OFF_MAX) ? '0 : cur_ff.off[sts] + 10'h001;
				end else if (cur_ff.valid[sts] && cur_ff.st[sts] == VALID_POINTER_STATE && dec_word && dec_maj) begin
					// h3 carries a data byte, offset steps down
					nxt.dec[sts] = 1'b1;
					nxt.off[sts] = (cur_ff.off[sts] == '0) ? OFF_MAX : cur_ff.off[sts] - 10'h001;
				end else if (!cur_ff.valid[sts] || word[OFF_W-1:0] != cur_ff.off[sts]) begin
					// one differing word is only remembered, the second one is taken
					if (cur_ff.diff[sts] && cur_ff.last[sts] == KIND_NORMAL) begin
						nxt.off[sts] = word[OFF_W-1:0];
						nxt.valid[sts] = 1'b1;
						nxt.jump[sts] = 1'b1;
					end else begin
						nxt.diff[sts] = 1'b1;
					end
				end
			end
			// chain members look back to the sts-1 that heads them
			nxt.head[sts] = (st_new == CHAINED_PAYLOAD_STATE && sts != STS_FIRST) ? nxt.head[psts] : sts;
		end
		// marker generation for the byte now leaving
		hs = (cur_ff.st[sts] == CHAINED_PAYLOAD_STATE) ? cur_ff.head[sts] : sts;
		carries = cur_ff.valid[hs] && cur_ff.st[hs] == VALID_POINTER_STATE
			&& cur_ff.st[sts] != AIS_STATE;
		in_pay = (col >= COL_PAY);
		h3_slot = (row == ROW_PTR) && (col == COL_H3);
		stuff_slot = (row == ROW_PTR) && (col == COL_PAY);
		ppos = 10'(ROW_BASE[row] + {3'h0, col} - 10'h003);
		// payload slots, minus an empty stuff byte, plus a filled h3
		payload_envelope_flag = carries && ((in_pay && !(stuff_slot && cur_ff.inc[hs]))
			|| (h3_slot && cur_ff.dec[hs]));
		// only the head marks its first payload byte
		j1 = payload_envelope_flag && in_pay && ppos == cur_ff.off[hs]
			&& cur_ff.st[sts] != CHAINED_PAYLOAD_STATE;
		// one trace slot per frame, on the first sts-1
		trace = (row == ROW_J0) && (col == COL_J0) && (sts == STS_FIRST);
		if (take && j1 && !BYPASS) begin
			nxt.jump[sts] = 1'b0; // jump flag goes out once with the j1
		end
		// overhead bytes, pointer spare bits included, pass untouched except in ais
		fifo_in = {1'b0, sts, 1'b0, 1'b0, IN_DATA};
		if (!BYPASS) begin
			fifo_in[14] = j1 && cur_ff.jump[sts];
			fifo_in[9] = payload_envelope_flag || j1;
			fifo_in[8] = j1 || (trace && !payload_envelope_flag);
			if (cur_ff.st[sts] == AIS_STATE) begin
				fifo_in[7:0] = AIS_FILL;
			end
		end else begin
			fifo_in[9:8] = 2'h0;
		end
	end
	// state register; every offset starts unknown
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cur_ff <= '{st: {12{VALID_POINTER_STATE}}, last: {12{KIND_OTHER}}, default: '0};
		end else begin
			cur_ff <= nxt;
		end
	end
endmodule : spm_mover

// *** design/spm_pkg.sv ***
package spm_pkg;
	// byte and word widths
	localparam int DATA_W = 8;
	localparam int OFF_W = 10;
	localparam int STS_W = 4;
	// fifo shape: {jump flag, sts index, envelope flag, trace flag, byte}
	localparam int FIFO_W = 15;
	localparam int FIFO_DEPTH = 32;
	// frame geometry: 12 interleaved sts-1s, 90 columns each, 9 rows
	localparam logic [3:0] NUM_STS = 4'hc;
	localparam logic [6:0] NUM_COLS = 7'h5a;
	localparam logic [3:0] NUM_ROWS = 4'h9;
	// column positions inside one sts-1
	localparam logic [6:0] COL_H1 = 7'h00;
	localparam logic [6:0] COL_H2 = 7'h01;
	localparam logic [6:0] COL_H3 = 7'h02;
	localparam logic [6:0] COL_J0 = 7'h02;
	localparam logic [6:0] COL_PAY = 7'h03;
	localparam logic [3:0] ROW_PTR = 4'h3;
	localparam logic [3:0] ROW_J0 = 4'h0;
	localparam logic [3:0] STS_FIRST = 4'h0;
	// largest legal offset, and the payload index at which each row starts
	localparam logic [9:0] OFF_MAX = 10'h30e;
	localparam logic [8:0][9:0] ROW_BASE = {10'h1b3, 10'h15c, 10'h105, 10'h0ae, 10'h057,
		10'h000, 10'h2b8, 10'h261, 10'h20a};
	// pointer word layout
	localparam logic [3:0] FLAG_SAME = 4'h6;
	localparam logic [3:0] FLAG_NEW = 4'h9;
	localparam logic [15:0] WORD_AIS = 16'hffff;
	localparam logic [9:0] PTR_CHAIN = 10'h3ff;
	localparam logic [9:0] MASK_INC = 10'h2aa;
	localparam logic [9:0] MASK_DEC = 10'h155;
	// vote thresholds
	localparam int VOTE_WORD = 8;
	localparam int VOTE_JUST = 3;
	localparam int VOTE_FLAG = 3;
	localparam logic [7:0] AIS_FILL = 8'hff;
	// interpreter states, one-hot
	typedef enum logic [2:0] {
		VALID_POINTER_STATE = 3'b001,
		AIS_STATE = 3'b010,
		CHAINED_PAYLOAD_STATE = 3'b100
	} spm_state_e;
	// class of one received pointer word
	typedef enum logic [1:0] {
		KIND_OTHER = 2'h0,
		KIND_NORMAL = 2'h1,
		KIND_AIS = 2'h2,
		KIND_CHAIN = 2'h3
	} spm_kind_e;
endpackage : spm_pkg

// *** design/spm_vote.sv ***
`timescale 1ns/1ns
// counts set bits and reports whether at least MIN of them are set
module spm_vote #(
	parameter int W = 4,
	parameter int MIN = 3
) (
	// bits under vote
	input wire logic [W-1:0] bits,
	// enough of them agree
	output logic hit
);
	int cnt; // running count of set bits
	// plain popcount, small enough to stay in one level of logic
	always_comb begin
		cnt = 0;
		for (int i = 0; i < W; i++) begin
			cnt = cnt + int'(bits[i]);
		end
		hit = (cnt >= MIN);
	end
endmodule : spm_vote

// *** dv/spm_mover_checker.sv ***
`timescale 1ns/1ns
// port-level checks on the mover
module spm_mover_checker import spm_pkg::*; (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// input stream and mode
	input wire logic IN_VALID,
	input wire logic IN_READY,
	input wire logic BYPASS,
	// output stream
	input wire logic [DATA_W-1:0] OUT_DATA,
	input wire logic OUT_PAYLOAD_ENVELOPE_FLAG,
	input wire logic OUT_TRACE_OR_PATH_START_FLAG,
	input wire logic OUT_POINTER_JUMP_FLAG,
	input wire logic [STS_W-1:0] OUT_STS,
	input wire logic OUT_VALID,
	input wire logic OUT_READY
);
	logic env, trc, jmp, put, got; // short aliases
	logic [6:0] cnt_ff; // words taken, not yet handed on
	logic [3:0] sts_ff; // sts of the last word handed on
	logic [3:0] want; // sts the next word must carry
	assign env = OUT_PAYLOAD_ENVELOPE_FLAG;
	assign trc = OUT_TRACE_OR_PATH_START_FLAG;
	assign jmp = OUT_POINTER_JUMP_FLAG;
	assign put = IN_VALID && IN_READY;
	assign got = OUT_VALID && OUT_READY;
	assign want = (sts_ff == NUM_STS - 4'h1) ? 4'h0 : sts_ff + 4'h1;
	// trackers restart with the slot counter, so the first word is sts 0
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cnt_ff <= 7'h00;
			sts_ff <= NUM_STS - 4'h1;
		end else begin
			cnt_ff <= cnt_ff + {6'h00, put} - {6'h00, got};
			if (got) begin
				sts_ff <= OUT_STS;
			end
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_reset_quiet: assert property ($rose(NRST) |-> !OUT_VALID && IN_READY)
		else $error("output busy after reset");
	a_sts_order: assert property (OUT_VALID |-> OUT_STS == want)
		else $error("sts index out of order");
	a_trace_first_sts: assert property (OUT_VALID && trc && !env |-> OUT_STS == STS_FIRST)
		else $error("trace flag outside sts 0");
	a_jump_on_j1: assert property (OUT_VALID && jmp |-> env && trc)
		else $error("jump flag off a j1 byte");
	// 40 cycles covers every word still in flight when the mode flips
	a_bypass_quiet: assert property (OUT_VALID && BYPASS && $past(BYPASS, 40) |-> !env && !trc && !jmp)
		else $error("marker set in bypass");
	a_word_stands: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({OUT_DATA, OUT_STS, env, trc, jmp}))
		else $error("output word changed while stalled");
	a_full_refuse: assert property (!IN_READY |-> cnt_ff >= 7'd32)
		else $error("input refused with room left");
	a_no_overrun: assert property (cnt_ff <= 7'd33)
		else $error("more words in flight than storage");
	a_first_out: assert property (cnt_ff == 7'h00 && put |-> ##[1:2] OUT_VALID)
		else $error("first word late");
endmodule : spm_mover_checker
bind spm_mover spm_mover_checker i_chk (.CLK(CLK), .NRST(NRST), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
	.BYPASS(BYPASS), .OUT_DATA(OUT_DATA), .OUT_PAYLOAD_ENVELOPE_FLAG(OUT_PAYLOAD_ENVELOPE_FLAG),
	.OUT_TRACE_OR_PATH_START_FLAG(OUT_TRACE_OR_PATH_START_FLAG), .OUT_POINTER_JUMP_FLAG(OUT_POINTER_JUMP_FLAG),
	.OUT_STS(OUT_STS), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));

// *** dv/spm_mover_tb.sv ***
`timescale 1ns/1ns
// each row is one frame of pointer words and the marker counts it should yield
module spm_mover_tb import spm_pkg::*;;
	typedef struct {
		logic byp;
		logic [15:0] w0, wh, wm, wc; // words: sts 0-2, chain head 3, members 4-5, sts 6-11
		int j1, tr, jp, payload_envelope_flag, ff, p; // -1 where not judged
	} spm_row_s;
	spm_row_s rows [10] = '{
		'{1'b0, 16'h6005, 16'h6005, 16'h93ff, 16'h6005, 0, 1, 0, 0, 0, -1},
		'{1'b0, 16'h6005, 16'h6005, 16'h93ff, 16'h6005, 10, 1, 10, -1, 0, 5},
		'{1'b0, 16'h7005, 16'h7005, 16'h93ff, 16'h7005, 10, 1, 0, 9396, 0, 5},
		'{1'b0, 16'h600a, 16'h600a, 16'h93ff, 16'h600a, 10, 1, 0, 9396, 0, 5},
		'{1'b0, 16'h6005, 16'h6014, 16'h93ff, 16'h6014, 10, 1, 7, -1, 0, 5},
		'{1'b0, 16'h6150, 16'h6014, 16'h93ff, 16'h62be, 10, 1, -1, 9393, 0, 4},
		'{1'b1, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 0, 0, 0, 0, 0, -1},
		'{1'b0, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 0, 1, 0, -1, -1, -1},
		'{1'b0, 16'h6004, 16'h6014, 16'h93ff, 16'h6015, 0, 1, 0, 0, 9396, -1},
		'{1'b0, 16'h6004, 16'h6014, 16'h93ff, 16'h6015, 10, 1, 10, -1, -1, 4}};
	logic CLK, NRST, IN_VALID, IN_FRAME, IN_READY, BYPASS, OUT_READY, hold;
	logic OUT_PAYLOAD_ENVELOPE_FLAG, OUT_TRACE_OR_PATH_START_FLAG, OUT_POINTER_JUMP_FLAG, OUT_VALID;
	logic [DATA_W-1:0] IN_DATA, OUT_DATA;
	logic [STS_W-1:0] OUT_STS;
	int n_fail = 0;
	int samples_checked = 0;
	int fr = -1; // frame being judged
	int k;
	spm_mover i_dut (.CLK(CLK), .NRST(NRST), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID), .IN_FRAME(IN_FRAME),
		.IN_READY(IN_READY), .BYPASS(BYPASS), .OUT_DATA(OUT_DATA), .OUT_PAYLOAD_ENVELOPE_FLAG(OUT_PAYLOAD_ENVELOPE_FLAG),
		.OUT_TRACE_OR_PATH_START_FLAG(OUT_TRACE_OR_PATH_START_FLAG), .OUT_POINTER_JUMP_FLAG(OUT_POINTER_JUMP_FLAG),
		.OUT_STS(OUT_STS), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));
	spm_sink i_sink (.clk(CLK), .nrst(NRST), .data(OUT_DATA), .env(OUT_PAYLOAD_ENVELOPE_FLAG),
		.trace(OUT_TRACE_OR_PATH_START_FLAG), .jump(OUT_POINTER_JUMP_FLAG), .valid(OUT_VALID),
		.ready(OUT_READY), .hold(hold));
	// 250 MHz
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// counts compare; a negative expectation means the frame is not judged on it
	task automatic chk_int(input string nm, input int exp, input int got);
		if (exp >= 0) begin
			samples_checked++;
			if (exp != got) begin
				n_fail++;
				$display("unexpected %s frame %0d expected %0d seen %0d", nm, fr, exp, got);
			end
		end
	endtask : chk_int
	// flag compare, unknown never matches
	task automatic chk_bit(input string nm, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk_bit
	// offers n bytes of a frame; a byte holds until an edge that found ready high
	task automatic send(input spm_row_s r, input int n);
		int s, rw, cl;
		logic [15:0] w;
		for (int i = 0; i < n; i++) begin
			s = i % 12;
			rw = i / 1080;
			cl = (i % 1080) / 12;
			w = (s < 3) ? r.w0 : (s == 3) ? r.wh : (s < 6) ? r.wm : r.wc;
			@(negedge CLK);
			BYPASS = r.byp;
			IN_VALID = 1'b1;
			IN_FRAME = (i == 0);
			IN_DATA = (rw != 3 || cl > 1) ? 8'h5a : (cl == 0) ? w[15:8] : w[7:0];
			while (!IN_READY) @(negedge CLK);
		end
		@(negedge CLK);
		IN_VALID = 1'b0;
	endtask : send
	// the one place the run ends
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	// ten frames at one byte a cycle, the sink's rare stalls and the tail tests, with a small margin
	initial begin
		repeat (100000) @(posedge CLK);
		n_fail++;
		end_sim();
	end
	initial begin
		{NRST, IN_VALID, IN_FRAME, BYPASS, hold} = 5'h00;
		IN_DATA = 8'h00;
		repeat (10) @(negedge CLK);
		NRST = 1'b1;
		foreach (rows[f]) send(rows[f], 9720);
		for (k = 0; k < 2000 && i_sink.n_frames < 10; k++) @(posedge CLK);
		foreach (rows[f]) begin
			fr = f;
			chk_int("j1 count", rows[f].j1, i_sink.res_j1[f]);
			chk_int("trace count", rows[f].tr, i_sink.res_tr[f]);
			chk_int("jump count", rows[f].jp, i_sink.res_jp[f]);
			chk_int("envelope count", rows[f].payload_envelope_flag, i_sink.res_spe[f]);
			chk_int("fill count", rows[f].ff, i_sink.res_ff[f]);
			chk_int("j1 position", rows[f].p, i_sink.res_p[f]);
		end
		// reset lands in mid-frame
		fork
			send(rows[1], 300);
		join_none
		repeat (100) @(posedge CLK);
		#1;
		disable fork;
		NRST = 1'b0;
		IN_VALID = 1'b0;
		@(negedge CLK);
		chk_bit("out_valid", 1'b0, OUT_VALID);
		chk_bit("in_ready", 1'b1, IN_READY);
		NRST = 1'b1;
		// fill the buffer until refused, then drain it empty
		hold = 1'b1;
		fork
			send(rows[1], 60);
		join_none
		repeat (50) @(negedge CLK);
		chk_bit("in_ready", 1'b0, IN_READY);
		hold = 1'b0;
		wait fork;
		repeat (60) @(negedge CLK);
		fr = 10;
		chk_int("words", 60, i_sink.n_words);
		chk_bit("out_valid", 1'b0, OUT_VALID);
		end_sim();
	end
endmodule : spm_mover_tb

// *** dv/spm_sink.sv ***
`timescale 1ns/1ns
// user logic stand-in: drains with a rare stall and tallies markers per frame
module spm_sink import spm_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// stream from the mover
	input wire logic [DATA_W-1:0] data,
	input wire logic env,
	input wire logic trace,
	input wire logic jump,
	input wire logic valid,
	output logic ready,
	// bench control
	input wire logic hold
);
	int n_words, n_frames, idx, rw, cl, st, c_j1, c_tr, c_jp, c_spe, c_ff, c_p;
	int res_j1 [10], res_tr [10], res_jp [10], res_spe [10], res_ff [10], res_p [10];
	logic [5:0] cyc; // stall pacing
	// per-frame tallies start over
	task automatic clr;
		c_j1 = 0;
		c_tr = 0;
		c_jp = 0;
		c_spe = 0;
		c_ff = 0;
		c_p = -1;
	endtask : clr
	// slot position is rebuilt from the word count, the stream being gapless
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready <= 1'b0;
			cyc = 6'h00;
			n_words = 0;
			n_frames = 0;
			idx = 0;
			clr();
		end else begin
			cyc = cyc + 6'h01;
			if (valid && ready) begin
				rw = idx / 1080;
				cl = (idx % 1080) / 12;
				st = idx % 12;
				c_j1 += int'(env && trace);
				c_tr += int'(!env && trace);
				c_jp += int'(jump);
				c_spe += int'(env);
				c_ff += int'(cl > 2 && data == 8'hff);
				if (env && trace && st == 0) begin
					c_p = int'(ROW_BASE[rw]) + cl - 3;
				end
				n_words++;
				idx++;
				if (idx == 9720 && n_frames < 10) begin
					res_j1[n_frames] = c_j1;
					res_tr[n_frames] = c_tr;
					res_jp[n_frames] = c_jp;
					res_spe[n_frames] = c_spe;
					res_ff[n_frames] = c_ff;
					res_p[n_frames] = c_p;
					n_frames++;
					idx = 0;
					clr();
				end
			end
			// one stall in 64 cycles keeps the output register standing at times
			ready <= !hold && cyc != 6'h3f;
		end
	end
endmodule : spm_sink
